//--- design/spd_eeprom_slave.sv
// The register addresses and the APB slave port are this design's own decisions.
`include "spd_consts.svh"

// Behaviour
// - Data changes only while clock low.
// - Ignore everything until a start condition.
// - Stop ends transfer, enter standby.
// - Transmitter releases; receiver acks ninth clock.
// - Acknowledge a matching select byte.
// - Acknowledge every write byte received, data bytes only with write control low.
// - Read: send byte, continue on acknowledge.
// - No acknowledge: release, wait for stop.
// - Select byte sent MSB first.
// - Memory code 1010, pins b3..b1.
// - Code 0110 selects the protection register.
// - Current read returns byte at counter.
// - Random read: address write, restart, read.
// - Sequential read while master keeps acknowledging.
// - Byte write only with write control low.
// - Page write up to sixteen bytes.
// - After write stop, ignore select during programming.
module spd_eeprom_slave #(
    parameter int unsigned WRITE_CYCLE_CYCLES = `WRITE_CYCLE_CYC
) (
    input wire logic LINK_CLK_I,
    input wire logic RST_N_I,
    input wire logic ADDR_SEL_PIN_0_I,
    input wire logic ADDR_SEL_PIN_1_I,
    input wire logic ADDR_SEL_PIN_2_I,
    input wire logic WRITE_CONTROL_PIN_I,
    output logic STANDBY_O,
    spd_link_if.device link
);
    import spd_pkg::*;

    // ****************************************
    // State.
    // ****************************************
    dev_regs_t r_reg;
    dev_regs_t r_next;
    logic [7:0] mem [`MEM_WORDS];
    logic we;
    logic [7:0] wa;
    logic [7:0] wd;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic load;
    logic [7:0] rdata;

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        r_next = r_reg;
        we = 1'b0;
        wa = r_reg.addr;
        wd = r_reg.sh;
        load = 1'b0;
        r_next.drv0 = 1'b0;
        r_next.s1 = {WRITE_CONTROL_PIN_I, ADDR_SEL_PIN_2_I, ADDR_SEL_PIN_1_I,
                     ADDR_SEL_PIN_0_I, link.sda, link.scl};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < 6; i++) begin
            r_next.f[i] = agree(r_reg.f[i], r_reg.s2[i], r_reg.s3[i]);
        end
        scl_rise = !r_reg.f[0] && r_next.f[0];
        scl_fall = r_reg.f[0] && !r_next.f[0];
        // Only data edges during a steady high clock are framing; all else is data.
        start = r_reg.f[0] && r_next.f[0] && r_reg.f[1] && !r_next.f[1];
        stop = r_reg.f[0] && r_next.f[0] && !r_reg.f[1] && r_next.f[1];
        rdata = r_reg.prot ? r_reg.prot_reg : mem[r_reg.addr];
        if (r_reg.busy != 20'h0) begin
            r_next.busy = r_reg.busy - 20'h1;
        end
        if (stop) begin
            r_next.st = D_IDLE;
            r_next.sda_low = 1'b0;
            if (r_reg.wrote) begin
                r_next.busy = WRITE_CYCLE_CYCLES[19:0];
                r_next.wrote = 1'b0;
            end
        end else if (start) begin
            r_next.sda_low = 1'b0;
            r_next.bits = 4'h0;
            r_next.ph = P_SEL;
            // While programming, the interface stays deaf to its own address.
            if (r_reg.busy == 20'h0) begin
                r_next.st = D_RX;
            end else begin
                r_next.st = D_IDLE;
            end
        end else begin
            case (r_reg.st)
                D_RX: begin
                    if (scl_rise) begin
                        r_next.sh = {r_reg.sh[6:0], r_reg.f[1]};
                        r_next.bits = r_reg.bits + 4'h1;
                    end else if (scl_fall && r_reg.bits == 4'h8) begin
                        r_next.bits = 4'h0;
                        case (r_reg.ph)
                            P_SEL: begin
                                if ((r_reg.sh[7:4] == `SEL_MEM_CODE
                                     || r_reg.sh[7:4] == `SEL_PROT_CODE)
                                    && r_reg.sh[3:1] == r_reg.f[4:2]) begin
                                    r_next.sda_low = 1'b1;
                                    r_next.rd = r_reg.sh[0];
                                    r_next.prot = (r_reg.sh[7:4] == `SEL_PROT_CODE);
                                    r_next.ph = P_ADDR;
                                    r_next.st = D_ACK;
                                end else begin
                                    r_next.st = D_WAIT;
                                end
                            end
                            P_ADDR: begin
                                r_next.addr = r_reg.sh;
                                r_next.ph = P_DATA;
                                r_next.sda_low = 1'b1;
                                r_next.st = D_ACK;
                            end
                            default: begin
                                if (r_reg.f[5]) begin
                                    r_next.st = D_WAIT;
                                end else begin
                                    we = !r_reg.prot;
                                    if (r_reg.prot) begin
                                        r_next.prot_reg = r_reg.sh;
                                    end
                                    // Page write wraps inside the sixteen-byte page.
                                    r_next.addr = {r_reg.addr[7:4],
                                                   r_reg.addr[3:0] + 4'h1};
                                    r_next.wrote = 1'b1;
                                    r_next.sda_low = 1'b1;
                                    r_next.st = D_ACK;
                                end
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    if (scl_fall) begin
                        r_next.sda_low = 1'b0;
                        r_next.bits = 4'h0;
                        if (r_reg.rd) begin
                            load = 1'b1;
                        end else begin
                            r_next.st = D_RX;
                        end
                    end
                end
                D_TX: begin
                    if (scl_fall) begin
                        if (r_reg.bits == 4'h7) begin
                            r_next.sda_low = 1'b0;
                            r_next.st = D_MACK;
                        end else begin
                            r_next.bits = r_reg.bits + 4'h1;
                            r_next.sh = {r_reg.sh[6:0], 1'b0};
                            r_next.sda_low = !r_reg.sh[6];
                        end
                    end
                end
                D_MACK: begin
                    if (scl_rise) begin
                        r_next.mack = !r_reg.f[1];
                    end else if (scl_fall) begin
                        if (r_reg.mack) begin
                            load = 1'b1;
                        end else begin
                            r_next.st = D_WAIT;
                        end
                    end
                end
                D_WAIT: begin
                    r_next.sda_low = 1'b0;
                end
                D_IDLE: begin
                    r_next.sda_low = 1'b0;
                end
                default: begin
                    r_next.st = D_IDLE;
                end
            endcase
        end
        if (load) begin
            r_next.sh = rdata;
            r_next.bits = 4'h0;
            r_next.sda_low = !rdata[7];
            r_next.addr = r_reg.addr + 8'h1;
            r_next.st = D_TX;
        end
        r_next.standby = (r_next.st == D_IDLE) && (r_next.busy == 20'h0);
    end

    // ****************************************
    // Registers.
    // ****************************************
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // The array holds no reset, so its contents are unknown until written.
    always_ff @(posedge LINK_CLK_I) begin
        if (we) begin
            mem[wa] <= wd;
        end
    end

    assign link.dev_sda_oe = r_reg.sda_low;
    assign link.dev_sda_out = r_reg.drv0;
    assign STANDBY_O = r_reg.standby;

endmodule : spd_eeprom_slave

//--- design/spd_consts.svh
`ifndef SPD_CONSTS_SVH
`define SPD_CONSTS_SVH

// ****************************************
// Select codes and memory layout.
// ****************************************
`define SEL_MEM_CODE 4'ha
`define SEL_PROT_CODE 4'h6
`define MEM_WORDS 256

// ****************************************
// Timing.
// ****************************************
`define WRITE_CYCLE_TIME_US 10000
`define LINK_PERIOD_NS 15
`define WRITE_CYCLE_CYC ((`WRITE_CYCLE_TIME_US * 1000) / `LINK_PERIOD_NS)
`define CLK_PERIOD_NS 8
`define SCL_HALF_NS 1300
`define SCL_QUARTER_CYC ((`SCL_HALF_NS / 2 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// Controller register map.
// ****************************************
`define REG_CMD 8'h00
`define REG_TXDATA 8'h04
`define REG_STATUS 8'h08
`define CMD_START 3'h1
`define CMD_STOP 3'h2
`define CMD_WRITE 3'h3
`define CMD_READ 3'h4
`define CMD_NACK_BIT 8

`endif

//--- design/spd_pkg.sv
package spd_pkg;

    typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK, D_WAIT} dev_state_t;
    typedef enum logic [1:0] {P_SEL, P_ADDR, P_DATA} phase_t;
    typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BITS} host_state_t;

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic [5:0] s3;
        logic [5:0] f;
        dev_state_t st;
        phase_t ph;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] addr;
        logic rd;
        logic prot;
        logic mack;
        logic wrote;
        logic sda_low;
        logic drv0;
        logic standby;
        logic [19:0] busy;
        logic [7:0] prot_reg;
    } dev_regs_t;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] f;
        host_state_t st;
        logic [1:0] ph;
        logic [7:0] qc;
        logic [3:0] bits;
        logic [8:0] tx;
        logic [8:0] rx;
        logic [7:0] txdata;
        logic [7:0] rxdata;
        logic ack;
        logic scl_low;
        logic sda_low;
        logic drv0;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } host_regs_t;

    // A filtered level follows the input only once two synchroniser stages agree.
    function automatic logic agree(input logic old, input logic q2, input logic q3);
        return (q2 & q3) | (old & (q2 | q3));
    endfunction : agree

endpackage : spd_pkg

//--- design/spd_link_if.sv
interface spd_link_if;
    logic host_scl_out;
    logic host_scl_oe;
    logic host_sda_out;
    logic host_sda_oe;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups: a line is low while any enabled driver pulls it low.
    assign scl = !(host_scl_oe && !host_scl_out);
    assign sda = !(host_sda_oe && !host_sda_out) && !(dev_sda_oe && !dev_sda_out);

    modport host (
        output host_scl_out,
        output host_scl_oe,
        output host_sda_out,
        output host_sda_oe,
        input scl,
        input sda
    );

    modport device (
        output dev_sda_out,
        output dev_sda_oe,
        input scl,
        input sda
    );
endinterface : spd_link_if

//--- design/spd_bus_master.sv
`include "spd_consts.svh"

module spd_bus_master (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    spd_link_if.host link
);
    import spd_pkg::*;

    host_regs_t r_reg;
    host_regs_t r_next;
    logic acc;
    logic tick;

    // ****************************************
    // Next state.
    // ****************************************
    always_comb begin
        r_next = r_reg;
        r_next.drv0 = 1'b0;
        r_next.s1 = {link.sda, link.scl};
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int i = 0; i < 2; i++) begin
            r_next.f[i] = agree(r_reg.f[i], r_reg.s2[i], r_reg.s3[i]);
        end
        tick = (r_reg.qc == 8'(`SCL_QUARTER_CYC - 1));
        if (r_reg.st == H_IDLE || tick) begin
            r_next.qc = 8'h0;
        end else begin
            r_next.qc = r_reg.qc + 8'h1;
        end
        // The answer comes one cycle into the access phase, so every access is three cycles, setup included.
        acc = PSEL_I && PENABLE_I && !r_reg.pready;
        r_next.pready = acc;
        r_next.pslverr = 1'b0;
        r_next.prdata = 32'h0;
        if (tick) begin
            r_next.ph = r_reg.ph + 2'h1;
            case (r_reg.st)
                H_START: begin
                    case (r_reg.ph)
                        2'h0: r_next.sda_low = 1'b0;
                        2'h1: r_next.scl_low = 1'b0;
                        2'h2: r_next.sda_low = 1'b1;
                        default: begin
                            r_next.scl_low = 1'b1;
                            r_next.st = H_IDLE;
                        end
                    endcase
                end
                H_STOP: begin
                    case (r_reg.ph)
                        2'h0: r_next.sda_low = 1'b1;
                        2'h1: r_next.scl_low = 1'b0;
                        2'h2: r_next.sda_low = 1'b0;
                        default: r_next.st = H_IDLE;
                    endcase
                end
                H_BITS: begin
                    case (r_reg.ph)
                        2'h0: r_next.sda_low = !r_reg.tx[8];
                        2'h1: r_next.scl_low = 1'b0;
                        2'h2: r_next.rx = {r_reg.rx[7:0], r_reg.f[1]};
                        default: begin
                            r_next.scl_low = 1'b1;
                            r_next.tx = {r_reg.tx[7:0], 1'b1};
                            r_next.bits = r_reg.bits + 4'h1;
                            if (r_reg.bits == 4'h8) begin
                                r_next.rxdata = r_reg.rx[8:1];
                                r_next.ack = !r_reg.rx[0];
                                r_next.st = H_IDLE;
                            end
                        end
                    endcase
                end
                default: r_next.st = H_IDLE;
            endcase
        end
        if (acc) begin
            case (PADDR_I)
                `REG_CMD: begin
                    // A command given while the link is busy is dropped, not queued.
                    if (PWRITE_I && r_reg.st == H_IDLE) begin
                        r_next.ph = 2'h0;
                        r_next.bits = 4'h0;
                        case (PWDATA_I[2:0])
                            `CMD_START: r_next.st = H_START;
                            `CMD_STOP: r_next.st = H_STOP;
                            `CMD_WRITE: begin
                                r_next.tx = {r_reg.txdata, 1'b1};
                                r_next.st = H_BITS;
                            end
                            `CMD_READ: begin
                                r_next.tx = {8'hff, PWDATA_I[`CMD_NACK_BIT]};
                                r_next.st = H_BITS;
                            end
                            default: r_next.st = H_IDLE;
                        endcase
                    end
                end
                `REG_TXDATA: begin
                    if (PWRITE_I) begin
                        r_next.txdata = PWDATA_I[7:0];
                    end else begin
                        r_next.prdata = {24'h0, r_reg.txdata};
                    end
                end
                `REG_STATUS: begin
                    if (!PWRITE_I) begin
                        r_next.prdata = {16'h0, r_reg.rxdata, 6'h0, r_reg.ack,
                                         r_reg.st != H_IDLE};
                    end
                end
                default: r_next.pslverr = 1'b1;
            endcase
        end
    end

    // ****************************************
    // Registers.
    // ****************************************
    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign PRDATA_O = r_reg.prdata;
    assign PREADY_O = r_reg.pready;
    assign PSLVERR_O = r_reg.pslverr;
    assign link.host_scl_oe = r_reg.scl_low;
    assign link.host_scl_out = r_reg.drv0;
    assign link.host_sda_oe = r_reg.sda_low;
    assign link.host_sda_out = r_reg.drv0;

endmodule : spd_bus_master

//--- tb/spd_link_assertions.sv
module spd_link_assertions #(
    parameter int unsigned WRITE_CYCLE_CYCLES = 3000
) (
    input wire logic CLOCK_I,
    input wire logic LINK_CLK_I,
    input wire logic RST_N_I,
    input wire logic STANDBY_O,
    input wire logic host_scl_out,
    input wire logic host_scl_oe,
    input wire logic host_sda_out,
    input wire logic host_sda_oe,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Line events seen from the link domain.
    // ****************************************
    logic scl_q, sda_q, seen_start, start_ev, stop_ev;
    logic [15:0] wait_cnt;
    assign start_ev = scl && scl_q && sda_q && !sda;
    assign stop_ev = scl && scl_q && !sda_q && sda;
    // The counter runs from a stop until standby or the next start; a write stop may add the programming time.
    always_ff @(posedge LINK_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            seen_start <= 1'b0;
            wait_cnt <= 16'h0;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_ev) begin
                seen_start <= 1'b1;
            end
            if (stop_ev) begin
                wait_cnt <= 16'h1;
            end else if (STANDBY_O || start_ev) begin
                wait_cnt <= 16'h0;
            end else if (wait_cnt != 16'h0) begin
                wait_cnt <= wait_cnt + 16'h1;
            end
        end
    end

    sequence s_start;
        scl && $fell(sda);
    endsequence
    sequence s_scl_rise;
        $rose(scl);
    endsequence

    property p_dev_change_low;
        @(posedge LINK_CLK_I) disable iff (!RST_N_I) $changed(dev_sda_oe) |-> !scl;
    endproperty
    a_dev_change_low: assert property (p_dev_change_low) else $error("device moved sda during high");
    property p_open_drain;
        @(posedge CLOCK_I) disable iff (!RST_N_I) !host_scl_out && !host_sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("host drives a line high");
    property p_start_wakes;
        @(posedge LINK_CLK_I) disable iff (!RST_N_I) s_start |-> ##[1:12] !STANDBY_O;
    endproperty
    a_start_wakes: assert property (p_start_wakes) else $error("standby kept after start");
    property p_stop_standby;
        @(posedge LINK_CLK_I) disable iff (!RST_N_I) wait_cnt <= WRITE_CYCLE_CYCLES + 40;
    endproperty
    a_stop_standby: assert property (p_stop_standby) else $error("no standby after stop");
    property p_standby_quiet;
        @(posedge LINK_CLK_I) disable iff (!RST_N_I) STANDBY_O |-> !dev_sda_oe;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("sda driven in standby");
    property p_no_drive_early;
        @(posedge LINK_CLK_I) disable iff (!RST_N_I) dev_sda_oe |-> seen_start;
    endproperty
    a_no_drive_early: assert property (p_no_drive_early) else $error("sda driven before start");
    property p_scl_high_hold;
        @(posedge CLOCK_I) disable iff (!RST_N_I) s_scl_rise |-> scl [*8];
    endproperty
    a_scl_high_hold: assert property (p_scl_high_hold) else $error("scl high too short");
    property p_scl_low_hold;
        @(posedge CLOCK_I) disable iff (!RST_N_I) $fell(scl) |-> !scl [*8];
    endproperty
    a_scl_low_hold: assert property (p_scl_low_hold) else $error("scl low too short");
endmodule : spd_link_assertions

//--- tb/presence_detect_eeprom_serial_slave_tb_top.sv
`include "spd_consts.svh"

module presence_detect_eeprom_serial_slave_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Long enough that a select sent right after a write stop lands inside programming.
    localparam int unsigned PROG_CYC = 3000;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, standby;
    logic [2:0] sa = 3'h0;
    logic wr_lock = 1'b0;
    int seed = 66810;
    int fail_count = 0;
    int compares = 0;

    always #4 clk = ~clk;
    always #7.5 link_clk = ~link_clk;

    spd_link_if link_if ();
    spd_eeprom_slave #(.WRITE_CYCLE_CYCLES(PROG_CYC)) spd_eeprom_slave_inst (
        .LINK_CLK_I(link_clk), .RST_N_I(rst_n), .ADDR_SEL_PIN_0_I(sa[0]),
        .ADDR_SEL_PIN_1_I(sa[1]), .ADDR_SEL_PIN_2_I(sa[2]), .WRITE_CONTROL_PIN_I(wr_lock),
        .STANDBY_O(standby), .link(link_if.device));
    spd_bus_master spd_bus_master_inst (
        .CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .link(link_if.host));
    spd_link_assertions #(.WRITE_CYCLE_CYCLES(PROG_CYC)) spd_link_assertions_inst (
        .CLOCK_I(clk), .LINK_CLK_I(link_clk), .RST_N_I(rst_n), .STANDBY_O(standby),
        .host_scl_out(link_if.host_scl_out), .host_scl_oe(link_if.host_scl_oe),
        .host_sda_out(link_if.host_sda_out), .host_sda_oe(link_if.host_sda_oe),
        .dev_sda_out(link_if.dev_sda_out), .dev_sda_oe(link_if.dev_sda_oe),
        .scl(link_if.scl), .sda(link_if.sda));

    // ****************************************
    // Checking and bus tasks.
    // ****************************************
    task automatic end_of_test();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic timeout(input string nm);
        fail_count++;
        $display("[FAIL] %s expected done seen timeout", nm);
        end_of_test();
    endtask : timeout

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            timeout("pready");
        end
    endtask : apb

    task automatic cmd(input logic [2:0] op, input logic nk, input logic [7:0] d,
                       output logic [31:0] st);
        logic e;
        int n;
        n = 0;
        apb(1'b1, `REG_TXDATA, {24'h0, d}, st, e);
        apb(1'b1, `REG_CMD, {23'h0, nk, 5'h0, op}, st, e);
        do begin
            apb(1'b0, `REG_STATUS, 32'h0, st, e);
            n++;
        end while (st[0] !== 1'b0 && n < 2000);
        if (st[0] !== 1'b0) begin
            timeout("busy");
        end
    endtask : cmd

    task automatic go(input logic [2:0] op);
        logic [31:0] st;
        cmd(op, 1'b0, 8'h00, st);
    endtask : go

    task automatic wb(input logic [7:0] b, input logic ack, input string nm);
        logic [31:0] st;
        cmd(`CMD_WRITE, 1'b0, b, st);
        chk(nm, {7'h0, ack}, {7'h0, st[1]});
    endtask : wb

    task automatic rb(input logic nk, input logic [7:0] exp, input string nm);
        logic [31:0] st;
        cmd(`CMD_READ, nk, 8'h00, st);
        chk(nm, exp, st[15:8]);
    endtask : rb

    task automatic wait_standby();
        int n;
        n = 0;
        while (standby !== 1'b1 && n < 8000) begin
            @(posedge clk);
            n++;
        end
        if (standby !== 1'b1) begin
            timeout("standby");
        end
    endtask : wait_standby

    function automatic logic [7:0] sel(input logic [3:0] code, input logic rw);
        return {code, sa, rw};
    endfunction : sel

    // Address inside the same 16-byte page, as a page write wraps.
    function automatic logic [7:0] wrap(input logic [7:0] a, input logic [3:0] k);
        return {a[7:4], a[3:0] + k};
    endfunction : wrap

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        logic [7:0] base, bw, pv;
        logic [7:0] pg [6];
        logic [31:0] r;
        logic e;
        sa = 3'($random(seed));
        base = 8'($random(seed));
        bw = 8'($random(seed));
        pv = 8'($random(seed));
        foreach (pg[i]) begin
            pg[i] = 8'($random(seed));
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        apb(1'b0, `REG_TXDATA, 32'h0, r, e);
        chk("txdata", 8'h00, r[7:0]);
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk("unmapped", 8'h01, {7'h0, e});
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b1, "sel_w");
        wb(wrap(base, 4'hd), 1'b1, "addr");
        wb(bw, 1'b1, "byte_data");
        go(`CMD_STOP);
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b0, "sel_prog");
        go(`CMD_STOP);
        wait_standby();
        wr_lock <= 1'b1;
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b1, "sel_lock");
        wb(wrap(base, 4'hd), 1'b1, "addr_lock");
        wb(~bw, 1'b0, "lock_data");
        go(`CMD_STOP);
        wr_lock <= 1'b0;
        wait_standby();
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b1, "sel_pg");
        wb(wrap(base, 4'he), 1'b1, "addr_pg");
        foreach (pg[i]) begin
            wb(pg[i], 1'b1, "page_data");
        end
        go(`CMD_STOP);
        wait_standby();
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b1, "sel_rr");
        wb(wrap(base, 4'hd), 1'b1, "addr_rr");
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b1), 1'b1, "sel_rd");
        rb(1'b0, bw, "rd_a");
        rb(1'b0, pg[0], "rd_b");
        rb(1'b1, pg[1], "rd_c");
        rb(1'b1, 8'hff, "after_nack");
        go(`CMD_STOP);
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b0), 1'b1, "sel_rr2");
        wb(wrap(base, 4'h0), 1'b1, "addr_rr2");
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b1), 1'b1, "sel_rd2");
        rb(1'b0, pg[2], "rd_wrap");
        rb(1'b1, pg[3], "rd_next");
        go(`CMD_STOP);
        go(`CMD_START);
        wb(sel(`SEL_MEM_CODE, 1'b1), 1'b1, "sel_cur");
        rb(1'b1, pg[4], "current");
        go(`CMD_STOP);
        go(`CMD_START);
        wb({`SEL_MEM_CODE, ~sa, 1'b1}, 1'b0, "wrong_pins");
        go(`CMD_STOP);
        go(`CMD_START);
        wb({4'h5, sa, 1'b1}, 1'b0, "wrong_code");
        go(`CMD_STOP);
        go(`CMD_START);
        wb(sel(`SEL_PROT_CODE, 1'b0), 1'b1, "sel_prot");
        wb(8'h00, 1'b1, "addr_prot");
        wb(pv, 1'b1, "prot_data");
        go(`CMD_STOP);
        wait_standby();
        go(`CMD_START);
        wb(sel(`SEL_PROT_CODE, 1'b1), 1'b1, "sel_prot_rd");
        rb(1'b1, pv, "prot_read");
        go(`CMD_STOP);
        end_of_test();
    end
endmodule : presence_detect_eeprom_serial_slave_tb_top
